// >>> hdl/terminal_dram_and_video_dma.sv
// dram sequencer, processor access, refresh and display fetch for the terminal
`timescale 1ns/100ps
`default_nettype none
module terminal_dram_and_video_dma
  import terminal_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic frame_rate_50,
  input wire logic mem_request_n,
  input wire logic refresh_cycle_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [15:0] low_address_bits,
  input wire logic bus_grant_n,
  input wire logic row_start_load_n,
  input wire logic [7:0] cpu_data_in,
  output logic [7:0] cpu_data_out,
  output logic cpu_data_oe,
  input wire logic [7:0] ram_dout,
  output logic [7:0] ram_din,
  output logic [6:0] ram_addr,
  output logic ram_write_n,
  output logic row_strobe_n,
  output logic column_addr_select,
  output logic column_addr_select_inv,
  output logic column_strobe_n,
  output logic bus_request_n,
  output logic nmi_n,
  output logic bus_grant_buffered,
  output logic bus_grant_buffered_n,
  output logic cpu_buf_enable,
  output logic [15:0] dma_addr,
  output logic dma_addr_oe,
  output logic line_rate_clock,
  output logic line_buffer_clock,
  output logic line_buffer_recirc_enable,
  output logic temp_buffer_recirc_enable,
  output logic [7:0] line_buffer_data,
  output logic dot_clock,
  output logic character_clock,
  output logic hsync,
  output logic vsync,
  output logic vblank
);

  // ----------------------------------------
  // raster timing
  // ----------------------------------------
  raster_if rif ();

  raster_timing u_raster (
    .clk(clk),
    .rstn(rstn),
    .frame_rate_50(frame_rate_50),
    .rif(rif)
  );

  assign hsync = rif.hsync;
  assign vsync = rif.vsync;
  assign vblank = rif.vblank;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // every processor pin is two flops late; the processor holds its
  // strobes for several clocks, so this only shifts the cycle start
  logic [5:0] ctl_meta;
  logic [5:0] ctl;
  logic [15:0] addr_meta;
  logic [15:0] addr;
  logic [7:0] wdata_meta;
  logic [7:0] wdata;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      ctl_meta <= 6'h3f;
      ctl <= 6'h3f;
    end
    else
    begin
      ctl_meta <= {row_start_load_n, bus_grant_n, write_strobe_n,
                   read_strobe_n, refresh_cycle_n, mem_request_n};
      ctl <= ctl_meta;
    end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      addr_meta <= 16'h0000;
      addr <= 16'h0000;
      wdata_meta <= 8'h00;
      wdata <= 8'h00;
    end
    else
    begin
      addr_meta <= low_address_bits;
      addr <= addr_meta;
      wdata_meta <= cpu_data_in;
      wdata <= wdata_meta;
    end

  logic mreq_n;
  logic rfsh_n;
  logic rd_n;
  logic wr_n;
  logic granted;
  logic rs_load_n;

  assign mreq_n = ctl[0];
  assign rfsh_n = ctl[1];
  assign rd_n = ctl[2];
  assign wr_n = ctl[3];
  assign granted = !ctl[4];
  assign rs_load_n = ctl[5];

  // ----------------------------------------
  // processor request decode
  // ----------------------------------------
  logic in_ram;
  logic cpu_req;
  logic cpu_read;

  assign in_ram = (addr[15:14] == RAM_TOP);
  // refresh may use any address; the processor owns the bus unless granted
  assign cpu_req = !mreq_n && (!rfsh_n || in_ram) && !granted;
  assign cpu_read = cpu_req && rfsh_n && !rd_n;

  // ----------------------------------------
  // ras / mux / cas shift register
  // ----------------------------------------
  // seq[0] row strobe, seq[1] column select, seq[2] column strobe,
  // seq[3] marks the end of a display fetch
  logic [3:0] seq;
  logic dma_cyc;
  logic dma_load;
  logic shift_in;
  logic fetch_line;

  assign shift_in = !(cpu_req || (dma_cyc && seq[3]));
  assign dma_load = rif.dot_en && (rif.dot_idx == LOAD_DOT)
                    && line_rate_clock && granted;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      seq <= SEQ_IDLE;
    else if (dma_load)
      seq <= SEQ_LOAD;
    else if (rif.dot_en)
      seq <= {seq[2:0], shift_in};

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      dma_cyc <= 1'b0;
    else if (dma_load)
      dma_cyc <= 1'b1;
    // held until column select ends, so the capture below still sees a fetch
    else if (rif.dot_en && !seq[1] && seq[0])
      dma_cyc <= 1'b0;

  assign row_strobe_n = seq[0];
  assign column_addr_select = !seq[1];
  assign column_addr_select_inv = seq[1];
  assign column_strobe_n = seq[2];

  // ----------------------------------------
  // ram address and write path
  // ----------------------------------------
  logic [13:0] eff_addr;

  assign eff_addr = granted ? dma_addr[13:0] : addr[13:0];
  assign ram_addr = column_addr_select ? eff_addr[13:7] : eff_addr[6:0];
  // refresh never writes, so the array contents stay put
  assign ram_write_n = !(cpu_req && rfsh_n && !wr_n);

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      ram_din <= DATA_RESET;
    else
      ram_din <= wdata;

  // ----------------------------------------
  // read latch
  // ----------------------------------------
  logic col_end;
  logic capture;

  // column select ends when seq[1] returns high on a dot edge
  assign col_end = rif.dot_en && !seq[1] && seq[0];
  assign capture = col_end && dma_cyc;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      line_buffer_data <= DATA_RESET;
    else if (cpu_read && column_addr_select)
      line_buffer_data <= ram_dout;
    else if (capture)
      line_buffer_data <= ram_dout;

  assign cpu_data_out = line_buffer_data;
  // writes and refresh leave the latch driver off
  assign cpu_data_oe = cpu_read || granted;

  // ----------------------------------------
  // bus ownership
  // ----------------------------------------
  assign bus_grant_buffered = granted;
  assign bus_grant_buffered_n = !granted;
  assign cpu_buf_enable = !granted;
  assign dma_addr_oe = granted;

  // ----------------------------------------
  // row start address
  // ----------------------------------------
  logic rs_load_prev;
  logic [3:0] upper;
  logic [11:0] start_low;
  logic [11:0] fetch_low;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rs_load_prev <= 1'b1;
    else
      rs_load_prev <= rs_load_n;

  // the top two bits are forced into the ram window
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      upper <= UPPER_RESET;
      start_low <= LOW_RESET;
    end
    else if (rs_load_prev && !rs_load_n)
    begin
      upper <= {RAM_TOP, addr[13:12]};
      start_low <= addr[11:0];
    end

  assign dma_addr = {upper, fetch_low};

  // ----------------------------------------
  // fetch windows
  // ----------------------------------------
  logic pre_lead;
  logic act_char;
  logic dma_scan;
  logic pre_scan;
  logic nmi_scan;
  logic next_lrc;

  assign pre_lead = (rif.char_idx >= LRC_START);
  assign act_char = (rif.char_idx < ACTIVE_CHARS);
  assign dma_scan = (rif.scan_idx == DMA_SCAN_A) || (rif.scan_idx == DMA_SCAN_B);
  assign pre_scan = (rif.scan_idx == DMA_SCAN_A - 4'h1)
                    || (rif.scan_idx == DMA_SCAN_B - 4'h1);
  assign nmi_scan = (rif.scan_idx == DMA_SCAN_A - 4'h1 - NMI_LEAD)
                    || (rif.scan_idx == DMA_SCAN_B - 4'h1 - NMI_LEAD);
  assign next_lrc = rif.active_line
                    && ((pre_scan && pre_lead) || (dma_scan && act_char));
  assign fetch_line = line_rate_clock && granted;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      line_rate_clock <= 1'b0;
      bus_request_n <= 1'b1;
      nmi_n <= 1'b1;
    end
    else
    begin
      line_rate_clock <= next_lrc;
      bus_request_n <= !next_lrc;
      nmi_n <= !(rif.active_line && nmi_scan && pre_lead);
    end

  // ----------------------------------------
  // fetch address counter
  // ----------------------------------------
  // the four early fetches all read the start address; only those made
  // in active video advance it and reach the line buffer
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      fetch_low <= LOW_RESET;
    else if (!line_rate_clock)
      fetch_low <= start_low;
    else if (capture && act_char && fetch_line)
      fetch_low <= fetch_low + 12'h001;

  // ----------------------------------------
  // line buffers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      line_buffer_clock <= 1'b0;
    else
      line_buffer_clock <= capture && act_char && fetch_line;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      line_buffer_recirc_enable <= 1'b1;
      temp_buffer_recirc_enable <= 1'b1;
    end
    else
    begin
      // scan 14 reloads the character buffer and moves temp into enhancement
      line_buffer_recirc_enable <= !(rif.active_line && rif.scan_idx == DMA_SCAN_B
                                     && granted);
      temp_buffer_recirc_enable <= !(rif.active_line && rif.scan_idx == DMA_SCAN_A
                                     && granted);
    end

  // ----------------------------------------
  // dot and character clocks for the video path
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      dot_clock <= 1'b0;
      character_clock <= 1'b0;
    end
    else
    begin
      dot_clock <= rif.dot_en;
      character_clock <= rif.dot_en && (rif.dot_idx == DOT_LAST);
    end

endmodule : terminal_dram_and_video_dma
`default_nettype wire

// >>> hdl/terminal_pkg.sv
// constants for the terminal dram controller and video fetch timing
package terminal_pkg;

  // ----------------------------------------
  // clock and character timing
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int CHAR_NS = 349;
  localparam int DOTS_PER_CHAR = 9;
  // a dot is the longest whole number of clocks inside one ninth of a character
  localparam int DOT_CYC_RAW = CHAR_NS / (DOTS_PER_CHAR * CLK_NS);
  localparam int DOT_CYC = (DOT_CYC_RAW < 1) ? 1 : DOT_CYC_RAW;
  localparam logic [1:0] DOT_DIV_LAST = 2'(DOT_CYC - 1);
  localparam logic [3:0] DOT_LAST = 4'h8;
  localparam logic [3:0] LOAD_DOT = 4'h3;

  // ----------------------------------------
  // horizontal timing, in character times
  // ----------------------------------------
  localparam logic [6:0] ACTIVE_CHARS = 7'h50;
  localparam logic [6:0] LINE_CHARS = 7'h73;
  localparam logic [6:0] HSYNC_LEAD = 7'h10;
  localparam logic [6:0] HSYNC_START = ACTIVE_CHARS - 7'h01 - HSYNC_LEAD;
  localparam logic [6:0] HSYNC_LEN = 7'h07;
  localparam logic [6:0] LRC_START = LINE_CHARS - 7'h04;

  // ----------------------------------------
  // vertical timing, in scan lines and character rows
  // ----------------------------------------
  localparam logic [3:0] SCAN_LAST = 4'he;
  localparam logic [4:0] ROWS = 5'h1a;
  localparam logic [8:0] ACTIVE_LINES = 9'h186;
  localparam logic [8:0] VS60_DELAY = 9'h000;
  localparam logic [8:0] VS60_WIDTH = 9'h013;
  localparam logic [8:0] FRAME60 = 9'h19f;
  localparam logic [8:0] VS50_DELAY = 9'h026;
  localparam logic [8:0] VS50_WIDTH = 9'h040;
  localparam logic [8:0] FRAME50 = 9'h1f2;

  // ----------------------------------------
  // display fetch and memory map
  // ----------------------------------------
  localparam logic [3:0] DMA_SCAN_A = 4'h6;
  localparam logic [3:0] DMA_SCAN_B = 4'he;
  localparam logic [3:0] NMI_LEAD = 4'h2;
  localparam logic [1:0] RAM_TOP = 2'h3;
  localparam logic [3:0] SEQ_IDLE = 4'hf;
  localparam logic [3:0] SEQ_LOAD = 4'he;
  localparam logic [3:0] UPPER_RESET = 4'hc;
  localparam logic [11:0] LOW_RESET = 12'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;

endpackage : terminal_pkg

// >>> hdl/raster_if.sv
// raster timing carried from the timing generator to the fetch logic
`timescale 1ns/100ps
`default_nettype none
interface raster_if;
  logic dot_en;
  logic [3:0] dot_idx;
  logic [6:0] char_idx;
  logic [3:0] scan_idx;
  logic active_line;
  logic hsync;
  logic vsync;
  logic vblank;

  modport src (
    output dot_en, dot_idx, char_idx, scan_idx, active_line, hsync, vsync, vblank
  );
  modport snk (
    input dot_en, dot_idx, char_idx, scan_idx, active_line, hsync, vsync, vblank
  );
endinterface : raster_if
`default_nettype wire

// >>> hdl/raster_timing.sv
// dot divider and horizontal and vertical raster counters
`timescale 1ns/100ps
`default_nettype none
module raster_timing
  import terminal_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic frame_rate_50,
  raster_if.src rif
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic in_window(input logic [8:0] v, input logic [8:0] lo,
                                     input logic [8:0] len);
    in_window = (v >= lo) && (v < 9'(lo + len));
  endfunction : in_window

  logic [1:0] div;
  logic [3:0] dot;
  logic [6:0] chr;
  logic [3:0] scan;
  logic [8:0] line;
  logic rate_meta;
  logic rate_50;
  logic [8:0] frame_len;
  logic [8:0] vs_start;
  logic [8:0] vs_width;
  logic dot_tick;
  logic line_tick;

  assign dot_tick = (div == DOT_DIV_LAST);
  assign line_tick = dot_tick && (dot == DOT_LAST) && (chr == LINE_CHARS - 7'h01);
  assign frame_len = rate_50 ? FRAME50 : FRAME60;
  assign vs_start = ACTIVE_LINES + (rate_50 ? VS50_DELAY : VS60_DELAY);
  assign vs_width = rate_50 ? VS50_WIDTH : VS60_WIDTH;

  // ----------------------------------------
  // counters
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      rate_meta <= 1'b0;
      rate_50 <= 1'b0;
    end
    else
    begin
      rate_meta <= frame_rate_50;
      rate_50 <= rate_meta;
    end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      div <= 2'h0;
    else
      div <= dot_tick ? 2'h0 : div + 2'h1;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      dot <= 4'h0;
      chr <= 7'h00;
    end
    else if (dot_tick)
    begin
      dot <= (dot == DOT_LAST) ? 4'h0 : dot + 4'h1;
      if (dot == DOT_LAST)
        chr <= (chr == LINE_CHARS - 7'h01) ? 7'h00 : chr + 7'h01;
    end

  // a rate change mid frame wraps at the new length at once
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      line <= 9'h000;
      scan <= 4'h0;
    end
    else if (line_tick)
    begin
      if (line >= frame_len - 9'h001)
      begin
        line <= 9'h000;
        scan <= 4'h0;
      end
      else
      begin
        line <= line + 9'h001;
        scan <= (scan == SCAN_LAST) ? 4'h0 : scan + 4'h1;
      end
    end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      rif.hsync <= 1'b0;
      rif.vsync <= 1'b0;
      rif.vblank <= 1'b0;
    end
    else
    begin
      rif.hsync <= in_window({2'h0, chr}, {2'h0, HSYNC_START}, {2'h0, HSYNC_LEN});
      rif.vblank <= (line >= ACTIVE_LINES);
      rif.vsync <= in_window(line, vs_start, vs_width);
    end

  assign rif.dot_en = dot_tick;
  assign rif.dot_idx = dot;
  assign rif.char_idx = chr;
  assign rif.scan_idx = scan;
  assign rif.active_line = (line < ACTIVE_LINES);

endmodule : raster_timing
`default_nettype wire

// >>> tb/terminal_dram_and_video_dma_sva.sv
// concurrent checks on the ports of the dram sequencer and display fetch
`timescale 1ns/100ps
`default_nettype none
module terminal_dram_and_video_dma_sva
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic cpu_data_oe,
  input wire logic ram_write_n,
  input wire logic row_strobe_n,
  input wire logic column_addr_select,
  input wire logic column_addr_select_inv,
  input wire logic column_strobe_n,
  input wire logic bus_request_n,
  input wire logic bus_grant_buffered,
  input wire logic bus_grant_buffered_n,
  input wire logic cpu_buf_enable,
  input wire logic dma_addr_oe,
  input wire logic line_rate_clock,
  input wire logic line_buffer_clock,
  input wire logic hsync
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic [8:0] hs_cnt;
  logic [7:0] gap;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      hs_cnt <= 9'h000;
    else
      hs_cnt <= hsync ? hs_cnt + 9'h001 : 9'h000;

  // saturates so the first pulse of a window is not judged against the last one
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      gap <= 8'hff;
    else
      gap <= line_buffer_clock ? 8'h01 : (gap == 8'hff ? gap : gap + 8'h01);

  AST_SEL_INV: assert property (column_addr_select_inv == !column_addr_select)
    else $error("column select and its inverse disagree");
  AST_ROW_FIRST: assert property ($rose(column_addr_select) |-> !row_strobe_n)
    else $error("column address selected without row strobe");
  AST_DOT_STEP: assert property ($fell(row_strobe_n) |-> ##3 $rose(column_addr_select))
    else $error("column select not one dot after row strobe");
  AST_CAS_LAST: assert property ($fell(column_strobe_n) |-> column_addr_select && !row_strobe_n)
    else $error("column strobe out of order");
  AST_IDLE: assert property ($rose(column_strobe_n) |-> row_strobe_n && !column_addr_select)
    else $error("sequencer not at rest after column strobe");
  AST_NO_RD_OE: assert property (read_strobe_n [*4] ##0 !bus_grant_buffered |-> !cpu_data_oe)
    else $error("read latch drives bus without a read");
  AST_WR_CAUSE: assert property (!ram_write_n |-> !$past(write_strobe_n, 2) || !$past(write_strobe_n, 3))
    else $error("ram write without write strobe");
  AST_GRANT: assert property (bus_grant_buffered != bus_grant_buffered_n && bus_grant_buffered == dma_addr_oe && bus_grant_buffered != cpu_buf_enable)
    else $error("grant outputs inconsistent");
  AST_LBC_GRANT: assert property (line_buffer_clock |-> bus_grant_buffered)
    else $error("line buffer clocked outside a fetch");
  AST_LBC_GAP: assert property (line_buffer_clock && gap < 8'd100 |-> gap == 8'd27)
    else $error("fetch spacing is not nine dots");
  AST_LRC_REQ: assert property ($rose(line_rate_clock) |-> !bus_request_n)
    else $error("line rate clock without bus request");
  AST_HS_LEN: assert property ($fell(hsync) |-> hs_cnt == 9'd189)
    else $error("horizontal sync width wrong");

  cover property ($fell(row_strobe_n));
  cover property (line_buffer_clock);
  cover property ($fell(bus_request_n));
endmodule : terminal_dram_and_video_dma_sva
`default_nettype wire

// >>> tb/cpu_model.sv
// processor model: memory cycles, bus release on request, row start loads
`timescale 1ns/100ps
`default_nettype none
module cpu_model
#(
  parameter int GRANT_LAG = 5,
  parameter logic [15:0] ROW_START = 16'h0123
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic bus_request_n,
  input wire logic nmi_n,
  output logic mem_request_n,
  output logic refresh_cycle_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [15:0] low_address_bits,
  output logic bus_grant_n,
  output logic row_start_load_n,
  output logic [7:0] cpu_data_in
);
  // ----------------------------------------
  // bus behaviour
  // ----------------------------------------
  int lag = 0;
  logic nmi_d = 1'b1;
  logic [6:0] rfsh_count = 7'h00;

  initial
  begin
    {mem_request_n, refresh_cycle_n, read_strobe_n, write_strobe_n} = 4'hf;
    {bus_grant_n, row_start_load_n} = 2'h3;
    low_address_bits = 16'h0000;
    cpu_data_in = 8'h00;
  end

  // grant comes late, as at the end of a machine cycle; released lines float
  always @(posedge clk)
  begin
    lag <= bus_request_n ? 0 : lag + 1;
    bus_grant_n <= bus_request_n | (lag < GRANT_LAG);
    nmi_d <= nmi_n;
    if (!bus_grant_n)
      low_address_bits <= ~low_address_bits;
  end

  always @(posedge clk)
    if (rstn && nmi_d && !nmi_n)
      load_row();

  task automatic load_row();
    low_address_bits <= ROW_START;
    row_start_load_n <= 1'b0;
    repeat (4) @(posedge clk);
    row_start_load_n <= 1'b1;
  endtask : load_row

  // kind: 0 read outside the ram window, 1 read, 2 write, 3 refresh
  task automatic access(input logic [1:0] kind, input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk);
    low_address_bits <= (kind == 2'd3) ? {9'h000, rfsh_count} : addr;
    rfsh_count <= rfsh_count + 7'h01;
    cpu_data_in <= data;
    mem_request_n <= 1'b0;
    refresh_cycle_n <= kind != 2'd3;
    read_strobe_n <= kind[1];
    repeat (4) @(posedge clk);
    write_strobe_n <= kind != 2'd2;
    repeat (28) @(posedge clk);
    {mem_request_n, refresh_cycle_n, read_strobe_n, write_strobe_n} <= 4'hf;
    cpu_data_in <= ~data;
    repeat (16) @(posedge clk);
  endtask : access
endmodule : cpu_model
`default_nettype wire

// >>> tb/terminal_dram_and_video_dma_tb_top.sv
// self-checking bench for the dram sequencer and display fetch
`timescale 1ns/100ps
`default_nettype none
module terminal_dram_and_video_dma_tb_top;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  logic clk, rstn, frame_rate_50, mem_request_n, refresh_cycle_n, read_strobe_n;
  logic write_strobe_n, bus_grant_n, row_start_load_n, cpu_data_oe, ram_write_n;
  logic row_strobe_n, column_addr_select, column_addr_select_inv, column_strobe_n;
  logic bus_request_n, nmi_n, bus_grant_buffered, bus_grant_buffered_n, cpu_buf_enable;
  logic dma_addr_oe, line_rate_clock, line_buffer_clock, line_buffer_recirc_enable;
  logic temp_buffer_recirc_enable, dot_clock, character_clock, hsync, vsync, vblank;
  logic [15:0] low_address_bits, dma_addr;
  logic [7:0] cpu_data_in, cpu_data_out, ram_dout, ram_din, line_buffer_data;
  logic [6:0] ram_addr;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int chars = 0;
  int t0, n;
  typedef struct packed {logic [1:0] kind; logic [15:0] addr; logic [7:0] data;} acc_s;
  acc_s rows [6] = '{'{2'd1, 16'hc000, 8'h00}, '{2'd2, 16'hffff, 8'ha5},
    '{2'd3, 16'h0000, 8'h00}, '{2'd0, 16'hbfff, 8'h00}, '{2'd1, 16'hffff, 8'h00},
    '{2'd2, 16'hc080, 8'h5a}};

  // array content follows the strobed address, so a wrong mux shows in the data
  assign ram_dout = {1'b1, ram_addr};

  terminal_dram_and_video_dma terminal_dram_and_video_dma_i (.clk, .rstn, .frame_rate_50,
    .mem_request_n, .refresh_cycle_n, .read_strobe_n, .write_strobe_n, .low_address_bits,
    .bus_grant_n, .row_start_load_n, .cpu_data_in, .cpu_data_out, .cpu_data_oe, .ram_dout,
    .ram_din, .ram_addr, .ram_write_n, .row_strobe_n, .column_addr_select,
    .column_addr_select_inv, .column_strobe_n, .bus_request_n, .nmi_n, .bus_grant_buffered,
    .bus_grant_buffered_n, .cpu_buf_enable, .dma_addr, .dma_addr_oe, .line_rate_clock,
    .line_buffer_clock, .line_buffer_recirc_enable, .temp_buffer_recirc_enable,
    .line_buffer_data, .dot_clock, .character_clock, .hsync, .vsync, .vblank);

  cpu_model cpu_model_i (.clk, .rstn, .bus_request_n, .nmi_n, .mem_request_n,
    .refresh_cycle_n, .read_strobe_n, .write_strobe_n, .low_address_bits, .bus_grant_n,
    .row_start_load_n, .cpu_data_in);

  // ----------------------------------------
  // tasks and tests
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(negedge clk)
  begin
    cycles++;
    if (character_clock === 1'b1)
      chars++;
    if (cycles == 60000)
    begin
      err_count++;
      results();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic dma_window(input logic last_scan);
    @(negedge nmi_n);
    t0 = cycles;
    @(negedge bus_request_n);
    check(16'(cycles - t0), 16'd6210);
    repeat (3) @(negedge clk);
    check({15'h0000, line_rate_clock}, 16'h0001);
    check(dma_addr, 16'hc123);
    n = 0;
    repeat (2400)
    begin
      @(negedge clk);
      if (line_buffer_clock === 1'b1)
      begin
        if (n == 0)
        begin
          check(line_buffer_data, 8'h82);
          check({bus_grant_buffered, dma_addr_oe, cpu_buf_enable}, 3'b110);
          check({line_buffer_recirc_enable, temp_buffer_recirc_enable}, {!last_scan, last_scan});
        end
        n++;
        // by the last fetch the address has advanced 80 past the row start
        if (n == 80)
          check(dma_addr, 16'hc173);
      end
    end
    check(16'(n), 16'd80);
    $display("fetch window test done");
  endtask : dma_window

  task automatic results();
    $display("%0d checks, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial
  begin
    frame_rate_50 = 1'b0;
    rstn = 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check({row_strobe_n, column_strobe_n, column_addr_select}, 3'b110);
    check({bus_request_n, nmi_n}, 2'b11);
    $display("reset test done");
    foreach (rows[i])
    begin
      fork
        cpu_model_i.access(rows[i].kind, rows[i].addr, rows[i].data);
        begin
          repeat (24) @(negedge clk);
          check({row_strobe_n, column_strobe_n}, {2{rows[i].kind == 2'd0}});
          check(ram_write_n, rows[i].kind != 2'd2);
          if (rows[i].kind != 2'd0)
            check(cpu_data_oe, rows[i].kind == 2'd1);
          if (rows[i].kind == 2'd1)
            check(cpu_data_out, {1'b1, rows[i].addr[13:7]});
          if (rows[i].kind == 2'd2)
            check(ram_din, rows[i].data);
        end
      join
      @(negedge clk);
      check({row_strobe_n, column_strobe_n, column_addr_select}, 3'b110);
    end
    $display("processor access test done");
    @(posedge hsync);
    t0 = cycles;
    n = chars;
    @(negedge hsync);
    check(16'(cycles - t0), 16'd189);
    @(posedge hsync);
    check(16'(cycles - t0), 16'd3105);
    check(16'(chars - n), 16'd115);
    $display("line timing test done");
    dma_window(1'b0);
    dma_window(1'b1);
    results();
  end
endmodule : terminal_dram_and_video_dma_tb_top

bind terminal_dram_and_video_dma terminal_dram_and_video_dma_sva terminal_dram_and_video_dma_sva_i (
  .clk, .rstn, .read_strobe_n, .write_strobe_n, .cpu_data_oe, .ram_write_n, .row_strobe_n,
  .column_addr_select, .column_addr_select_inv, .column_strobe_n, .bus_request_n,
  .bus_grant_buffered, .bus_grant_buffered_n, .cpu_buf_enable, .dma_addr_oe,
  .line_rate_clock, .line_buffer_clock, .hsync);
`default_nettype wire
